// >>> pps_pkg.sv
// constants, types and register map of the process regulator with slow-flow stop
package pps_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int DIV_W = 64;
  localparam int FRAC = 16;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [3:0] ADDR_GAIN = 4'h0;
  localparam logic [3:0] ADDR_TI = 4'h1;
  localparam logic [3:0] ADDR_TD = 4'h2;
  localparam logic [3:0] ADDR_TF = 4'h3;
  localparam logic [3:0] ADDR_PFREQ = 4'h4;
  localparam logic [3:0] ADDR_PDUR = 4'h5;
  localparam logic [3:0] ADDR_AWU = 4'h6;
  localparam logic [3:0] ADDR_SFREQ = 4'h7;
  localparam logic [3:0] ADDR_LAT = 4'h8;
  localparam logic [3:0] ADDR_RFREQ = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'hA;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'hB;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'hC;
  localparam logic [3:0] ADDR_IRQ_EN = 4'hD;
  localparam logic [3:0] ADDR_FREQ = 4'hE;
  localparam logic [3:0] ADDR_FILT = 4'hF;
  // ********************************
  // reset values and setting limits
  // ********************************
  localparam logic [15:0] GAIN_RST = 16'h0064;
  localparam logic [15:0] TI_RST = 16'h0000;
  localparam logic [15:0] TD_RST = 16'h0000;
  localparam logic [15:0] TF_RST = 16'h0000;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [15:0] AWU_RST = 16'h00C8;
  localparam logic [15:0] GAIN_MAX = 16'h7530;
  localparam logic [15:0] TI_MAX = 16'h8CA0;
  localparam logic [15:0] TD_MAX = 16'hEA60;
  localparam logic [15:0] TF_MAX = 16'h2328;
  localparam logic [15:0] FREQ_MAX = 16'h1388;
  localparam logic [15:0] FREQ_MIN_ON = 16'h000A;
  localparam logic [15:0] LAT_MAX = 16'h003C;
  localparam logic [15:0] AWU_MAX = 16'h00C8;
  localparam logic [15:0] MAX_FREQ_RST = 16'h1388;
  localparam int FS = 20000;
  localparam int PCT_FULL = 100;
  localparam int GAIN_ONE = 1000;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_S = 1_000_000 / TICK_US;
  localparam int TI_UNIT_US = 100_000;
  localparam int TF_UNIT_US = 100_000;
  localparam int TD_UNIT_US = 10_000;
  // ********************************
  // interrupt bits, sequencer phases and slow-flow states
  // ********************************
  localparam int IRQ_N = 3;
  localparam int IRQ_STOP = 0;
  localparam int IRQ_RESTART = 1;
  localparam int IRQ_PRESS = 2;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_FILT = 3'b001,
    PH_ERR = 3'b010,
    PH_INTEG = 3'b011,
    PH_PD = 3'b100,
    PH_SCALE = 3'b101
  } pps_phase_e;
  typedef enum logic [1:0] {
    SF_RUN = 2'b00,
    SF_WAIT = 2'b01,
    SF_PRESS = 2'b10,
    SF_STOP = 2'b11
  } pps_sf_e;
endpackage

// >>> pps_div_if.sv
// handshake between the regulator sequencer and its shared divider
`timescale 1ns/100ps
interface pps_div_if;
  import pps_pkg::*;
  logic start;
  logic signed [DIV_W-1:0] num;
  logic [DIV_W-1:0] den;
  logic done;
  logic signed [DIV_W-1:0] quo;
  modport master(output start, output num, output den, input done, input quo);
  modport slave(input start, input num, input den, output done, output quo);
endinterface

// >>> pps_div.sv
// serial signed-by-unsigned restoring divider, one quotient bit per clock
`timescale 1ns/100ps
module pps_div (
  input wire logic i_clk,
  input wire logic i_reset_n,
  pps_div_if.slave bus
);
  import pps_pkg::*;
  typedef struct packed {
    logic busy;
    logic done;
    logic neg;
    logic [5:0] cnt;
    logic [DIV_W-1:0] rem;
    logic [DIV_W-1:0] quo;
    logic [DIV_W-1:0] den;
  } pps_div_s;
  pps_div_s r;
  pps_div_s n;
  logic [DIV_W:0] sh;
  always_comb begin
    n = r;
    sh = '0;
    n.done = 1'b0;
    if (!r.busy && bus.start) begin
      n.busy = 1'b1;
      n.neg = bus.num[DIV_W-1];
      n.quo = bus.num[DIV_W-1] ? DIV_W'(-bus.num) : DIV_W'(bus.num);
      n.rem = '0;
      n.den = bus.den;
      n.cnt = 6'(DIV_W - 1);
    end else if (r.busy) begin
      sh = {r.rem, r.quo[DIV_W-1]};
      if (sh >= {1'b0, r.den}) begin
        n.rem = DIV_W'(sh - {1'b0, r.den});
        n.quo = {r.quo[DIV_W-2:0], 1'b1};
      end else begin
        n.rem = sh[DIV_W-1:0];
        n.quo = {r.quo[DIV_W-2:0], 1'b0};
      end
      if (r.cnt == 6'h00) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = r.cnt - 6'h01;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign bus.done = r.done;
  assign bus.quo = r.neg ? -$signed(r.quo) : $signed(r.quo);
endmodule

// >>> pps_pid_slow_flow.sv
// process regulator with feedback filter, anti-windup and slow-flow stop sequencing
`timescale 1ns/100ps
module pps_pid_slow_flow #(
  parameter int TICK_CYCLES_P = pps_pkg::TICK_CYCLES,
  parameter logic [15:0] MAX_FREQ = pps_pkg::MAX_FREQ_RST
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [pps_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pps_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pps_pkg::DATA_W-1:0] o_rdata,
  input wire logic [15:0] i_command,
  input wire logic [15:0] i_feedback,
  output logic [15:0] o_freq_ref,
  output logic o_run,
  output logic o_slow_flow_stopped_flag,
  output logic o_irq
);
  import pps_pkg::*;

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    pps_phase_e phase;
    pps_sf_e sf;
    logic [31:0] tick_cnt;
    logic [31:0] sf_cnt;
    logic [15:0] cmd_s1;
    logic [15:0] cmd_s2;
    logic [15:0] fb_s1;
    logic [15:0] fb_s2;
    logic [15:0] gain;
    logic [15:0] ti;
    logic [15:0] td;
    logic [15:0] tf;
    logic [15:0] pfreq;
    logic [15:0] pdur;
    logic [15:0] awu;
    logic [15:0] sfreq;
    logic [15:0] lat;
    logic [15:0] rfreq;
    logic [IRQ_N-1:0] irq_en;
    logic [IRQ_N-1:0] irq_stat;
    logic [15:0] rdata;
    logic [15:0] freq_out;
    logic [15:0] manipulated_value;
    logic [31:0] filt;
    logic [39:0] iacc;
    logic [17:0] e_cur;
    logic [17:0] e_prev;
    logic div_start;
    logic [DIV_W-1:0] div_num;
    logic [DIV_W-1:0] div_den;
  } pps_state_s;

  localparam pps_state_s ST_RST = '{
    phase: PH_IDLE,
    sf: SF_RUN,
    gain: GAIN_RST,
    ti: TI_RST,
    td: TD_RST,
    tf: TF_RST,
    awu: AWU_RST,
    default: '0
  };

  localparam logic signed [39:0] IACC_LIM = 40'(FS) <<< FRAC;

  pps_state_s r;
  pps_state_s n;
  pps_div_if dv();

  // ********************************
  // helpers
  // ********************************
  function automatic logic signed [63:0] smul(input logic signed [63:0] a, input logic signed [63:0] b);
    return a * b;
  endfunction

  function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // ********************************
  // combinational next state
  // ********************************
  logic signed [63:0] e_w;
  logic signed [63:0] de_w;
  logic signed [63:0] mag_w;
  logic signed [63:0] manip_w;
  logic signed [63:0] isum_w;
  logic [15:0] trig;
  logic sf_en;
  logic sf_upd;
  logic [15:0] sf_f;
  logic [IRQ_N-1:0] ev;
  logic [IRQ_N-1:0] clr;

  always_comb begin
    n = r;
    e_w = '0;
    de_w = '0;
    mag_w = '0;
    manip_w = '0;
    isum_w = '0;
    sf_upd = 1'b0;
    sf_f = r.manipulated_value;
    ev = '0;
    clr = '0;
    n.div_start = 1'b0;
    n.cmd_s1 = i_command;
    n.cmd_s2 = r.cmd_s1;
    n.fb_s1 = i_feedback;
    n.fb_s2 = r.fb_s1;
    n.tick_cnt = (r.tick_cnt >= 32'(TICK_CYCLES_P - 1)) ? 32'h0000_0000 : r.tick_cnt + 32'h0000_0001;

    // ********************************
    // regulator sequencer
    // ********************************
    case (r.phase)
      PH_IDLE: begin
        if (r.tick_cnt == 32'h0000_0000) begin
          if (r.sf == SF_PRESS) begin
            sf_upd = 1'b1;
          end else if (r.tf == 16'h0000) begin
            n.filt = {r.fb_s2, 16'h0000};
            n.phase = PH_ERR;
          end else begin
            n.div_num = smul($signed({1'b0, r.fb_s2, 16'h0000}) - $signed({1'b0, r.filt}), TICK_US);
            n.div_den = DIV_W'(smul({1'b0, r.tf}, TF_UNIT_US));
            n.div_start = 1'b1;
            n.phase = PH_FILT;
          end
        end
      end
      PH_FILT: begin
        if (dv.done) begin
          n.filt = 32'($signed({1'b0, r.filt}) + dv.quo);
          n.phase = PH_ERR;
        end
      end
      PH_ERR: begin
        e_w = $signed({1'b0, r.cmd_s2}) - $signed({1'b0, r.filt[31:16]});
        n.e_cur = 18'(e_w);
        mag_w = (e_w < 0) ? -e_w : e_w;
        n.div_start = 1'b1;
        if (r.ti == 16'h0000) begin
          n.iacc = '0;
          n.phase = PH_PD;
        end else if (mag_w > smul({1'b0, r.awu}, FS / PCT_FULL)) begin
          n.phase = PH_PD;
        end else begin
          n.div_num = smul(smul(e_w, {1'b0, r.gain}), 64'(TICK_US) <<< FRAC);
          n.div_den = DIV_W'(smul({1'b0, r.ti}, 64'(TI_UNIT_US) * GAIN_ONE));
          n.phase = PH_INTEG;
        end
        if (n.phase == PH_PD) begin
          de_w = e_w - $signed(r.e_prev);
          n.div_num = smul({1'b0, r.gain}, smul(e_w, TICK_US) + smul(de_w, smul({1'b0, r.td}, TD_UNIT_US)));
          n.div_den = DIV_W'(smul(GAIN_ONE, TICK_US));
        end
      end
      PH_INTEG: begin
        if (dv.done) begin
          isum_w = $signed(r.iacc) + dv.quo;
          if (isum_w > IACC_LIM) begin
            n.iacc = IACC_LIM;
          end else if (isum_w < -IACC_LIM) begin
            n.iacc = -IACC_LIM;
          end else begin
            n.iacc = 40'(isum_w);
          end
          de_w = $signed(r.e_cur) - $signed(r.e_prev);
          // td of zero makes the second product vanish, so no derivative term
          n.div_num = smul({1'b0, r.gain}, smul($signed(r.e_cur), TICK_US) + smul(de_w, smul({1'b0, r.td}, TD_UNIT_US)));
          n.div_den = DIV_W'(smul(GAIN_ONE, TICK_US));
          n.div_start = 1'b1;
          n.phase = PH_PD;
        end
      end
      PH_PD: begin
        if (dv.done) begin
          manip_w = dv.quo + ($signed(r.iacc) >>> FRAC);
          if (manip_w < 0) begin
            manip_w = '0;
          end else if (manip_w > FS) begin
            manip_w = 64'(FS);
          end
          n.div_num = smul(manip_w, {1'b0, MAX_FREQ});
          n.div_den = DIV_W'(FS);
          n.div_start = 1'b1;
          n.phase = PH_SCALE;
        end
      end
      PH_SCALE: begin
        if (dv.done) begin
          n.manipulated_value = 16'(dv.quo);
          n.e_prev = r.e_cur;
          sf_f = 16'(dv.quo);
          sf_upd = 1'b1;
          n.phase = PH_IDLE;
        end
      end
      default: begin
        n.phase = PH_IDLE;
      end
    endcase

    // ********************************
    // slow-flow stop sequencing, once per control tick
    // ********************************
    trig = (r.rfreq < r.sfreq) ? r.rfreq : r.sfreq;
    sf_en = (r.sfreq != 16'h0000);
    if (sf_upd) begin
      n.freq_out = sf_f;
      case (r.sf)
        SF_RUN: begin
          if (sf_en && sf_f < trig) begin
            n.sf = SF_WAIT;
            n.sf_cnt = '0;
          end
        end
        SF_WAIT: begin
          if (!sf_en || sf_f >= trig) begin
            n.sf = SF_RUN;
          end else if (r.sf_cnt >= 32'(smul({1'b0, r.lat}, TICKS_PER_S))) begin
            n.sf_cnt = '0;
            if (r.pfreq != 16'h0000 && r.pdur != 16'h0000) begin
              n.sf = SF_PRESS;
              n.freq_out = r.pfreq;
              ev[IRQ_PRESS] = 1'b1;
            end else begin
              n.sf = SF_STOP;
              ev[IRQ_STOP] = 1'b1;
            end
          end else begin
            n.sf_cnt = r.sf_cnt + 32'h0000_0001;
          end
        end
        SF_PRESS: begin
          n.freq_out = r.pfreq;
          if (r.sf_cnt >= 32'(smul({1'b0, r.pdur}, TICKS_PER_S) - 1)) begin
            n.sf = SF_STOP;
            n.freq_out = sf_f;
            ev[IRQ_STOP] = 1'b1;
          end else begin
            n.sf_cnt = r.sf_cnt + 32'h0000_0001;
          end
        end
        SF_STOP: begin
          if (sf_f > r.rfreq) begin
            n.sf = SF_RUN;
            ev[IRQ_RESTART] = 1'b1;
          end
        end
        default: begin
          n.sf = SF_RUN;
        end
      endcase
    end

    // ********************************
    // register writes
    // ********************************
    if (i_wr) begin
      if (i_addr == ADDR_GAIN) begin
        n.gain = sat16(i_wdata, GAIN_MAX);
      end else if (i_addr == ADDR_TI) begin
        n.ti = sat16(i_wdata, TI_MAX);
      end else if (i_addr == ADDR_TD) begin
        n.td = sat16(i_wdata, TD_MAX);
      end else if (i_addr == ADDR_TF) begin
        n.tf = sat16(i_wdata, TF_MAX);
      end else if (i_addr == ADDR_PFREQ) begin
        n.pfreq = sat16(i_wdata, FREQ_MAX);
      end else if (i_addr == ADDR_PDUR) begin
        n.pdur = i_wdata;
      end else if (i_addr == ADDR_AWU) begin
        n.awu = sat16(i_wdata, AWU_MAX);
      end else if (i_addr == ADDR_SFREQ) begin
        // a nonzero value under the lower bound is raised to it
        n.sfreq = (i_wdata == 16'h0000) ? 16'h0000 : ((i_wdata < FREQ_MIN_ON) ? FREQ_MIN_ON : sat16(i_wdata, FREQ_MAX));
      end else if (i_addr == ADDR_LAT) begin
        n.lat = sat16(i_wdata, LAT_MAX);
      end else if (i_addr == ADDR_RFREQ) begin
        n.rfreq = sat16(i_wdata, FREQ_MAX);
      end else if (i_addr == ADDR_IRQ_CLR) begin
        clr = i_wdata[IRQ_N-1:0];
      end else if (i_addr == ADDR_IRQ_EN) begin
        n.irq_en = i_wdata[IRQ_N-1:0];
      end
    end
    // a new event beats a clear in the same cycle
    n.irq_stat = (r.irq_stat & ~clr) | ev;

    // ********************************
    // register reads, data one cycle later
    // ********************************
    n.rdata = '0;
    if (i_rd) begin
      if (i_addr == ADDR_GAIN) begin
        n.rdata = r.gain;
      end else if (i_addr == ADDR_TI) begin
        n.rdata = r.ti;
      end else if (i_addr == ADDR_TD) begin
        n.rdata = r.td;
      end else if (i_addr == ADDR_TF) begin
        n.rdata = r.tf;
      end else if (i_addr == ADDR_PFREQ) begin
        n.rdata = r.pfreq;
      end else if (i_addr == ADDR_PDUR) begin
        n.rdata = r.pdur;
      end else if (i_addr == ADDR_AWU) begin
        n.rdata = r.awu;
      end else if (i_addr == ADDR_SFREQ) begin
        n.rdata = r.sfreq;
      end else if (i_addr == ADDR_LAT) begin
        n.rdata = r.lat;
      end else if (i_addr == ADDR_RFREQ) begin
        n.rdata = r.rfreq;
      end else if (i_addr == ADDR_STATUS) begin
        n.rdata = {13'h0000, (r.sf == SF_STOP), r.sf};
      end else if (i_addr == ADDR_IRQ_STAT) begin
        n.rdata = {13'h0000, r.irq_stat};
      end else if (i_addr == ADDR_IRQ_EN) begin
        n.rdata = {13'h0000, r.irq_en};
      end else if (i_addr == ADDR_FREQ) begin
        n.rdata = r.manipulated_value;
      end else if (i_addr == ADDR_FILT) begin
        n.rdata = r.filt[31:16];
      end
    end
  end

  // ********************************
  // state register
  // ********************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  // ********************************
  // shared divider, one quotient at a time keeps the arithmetic small
  // ********************************
  assign dv.start = r.div_start;
  assign dv.num = $signed(r.div_num);
  assign dv.den = r.div_den;

  pps_div u_div (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .bus(dv.slave)
  );

  // ********************************
  // outputs
  // ********************************
  assign o_rdata = r.rdata;
  assign o_freq_ref = r.freq_out;
  assign o_run = (r.sf != SF_STOP);
  assign o_slow_flow_stopped_flag = (r.sf == SF_STOP);
  assign o_irq = |(r.irq_stat & r.irq_en);
endmodule

// >>> pps_sensor_model.sv
// behavioural process feedback sensor
`timescale 1ns/100ps
module pps_sensor_model (
  input wire logic i_clk,
  input wire logic [15:0] i_level,
  output logic [15:0] o_feedback
);
  // registered on the bench's own edge, so the value follows the bench's level one clock later
  always_ff @(posedge i_clk) begin
    o_feedback <= i_level;
  end
endmodule

// >>> pps_pid_slow_flow_sva.sv
// port assertions for the slow-flow regulator
`timescale 1ns/100ps
module pps_pid_slow_flow_sva #(
  parameter int TICK_CYCLES_P = pps_pkg::TICK_CYCLES,
  parameter logic [15:0] MAX_FREQ = pps_pkg::MAX_FREQ_RST
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_rd,
  input wire logic [pps_pkg::DATA_W-1:0] o_rdata,
  input wire logic [15:0] o_freq_ref,
  input wire logic o_run,
  input wire logic o_slow_flow_stopped_flag
);
  import pps_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ****************
  // assertions
  // ****************
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_stop_entry: assert property ($rose(o_slow_flow_stopped_flag) |-> $fell(o_run))
    else $error("stop flag without deceleration");
  a_run_fall: assert property ($fell(o_run) |-> o_slow_flow_stopped_flag)
    else $error("run dropped without stop flag");
  a_flag_no_run: assert property (o_slow_flow_stopped_flag |-> !o_run)
    else $error("stop flag while running");
  a_restart_run: assert property ($fell(o_slow_flow_stopped_flag) |-> $rose(o_run))
    else $error("flag cleared without restart");
  a_stop_holds: assert property ($rose(o_slow_flow_stopped_flag) |=> o_slow_flow_stopped_flag [*8])
    else $error("stop left before next tick");
  a_ref_per_tick: assert property ($changed(o_freq_ref) |=> $stable(o_freq_ref) [*8])
    else $error("frequency moved twice in one tick");
  a_ref_max: assert property (o_freq_ref <= MAX_FREQ)
    else $error("frequency above maximum");
  a_reset_state: assert property ($rose(i_reset_n) |-> o_run && !o_slow_flow_stopped_flag
    && o_freq_ref == 16'h0000)
    else $error("outputs not at reset state");
endmodule
bind pps_pid_slow_flow pps_pid_slow_flow_sva #(.TICK_CYCLES_P(TICK_CYCLES_P), .MAX_FREQ(MAX_FREQ)) chk_u (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_rd(i_rd), .o_rdata(o_rdata), .o_freq_ref(o_freq_ref),
  .o_run(o_run), .o_slow_flow_stopped_flag(o_slow_flow_stopped_flag));

// >>> pps_tb.sv
// self-checking bench for the slow-flow regulator
`timescale 1ns/100ps
module tb;
  import pps_pkg::*;
  // short tick keeps the run small; must exceed the computation length
  localparam int TK = 400;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_command = 16'h0000;
  logic [15:0] level = 16'h0000;
  logic [15:0] fb;
  logic [15:0] o_rdata;
  logic [15:0] o_freq_ref;
  logic o_run;
  logic o_flag;
  logic o_irq;
  logic [15:0] rv;
  int cyc = 0;
  int n_fail = 0;
  int checks_done = 0;
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= i_reset_n ? cyc + 1 : 0;
  end
  pps_pid_slow_flow #(.TICK_CYCLES_P(TK), .MAX_FREQ(16'h1388)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_command(i_command), .i_feedback(fb), .o_freq_ref(o_freq_ref),
    .o_run(o_run), .o_slow_flow_stopped_flag(o_flag), .o_irq(o_irq));
  pps_sensor_model sens_u (.i_clk(i_clk), .i_level(level), .o_feedback(fb));
  // ****************
  // shared tasks
  // ****************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
    check(what, exp, rv);
  endtask
  task automatic outs(input logic [15:0] f, input logic run, input logic flag);
    check("freq_ref", f, o_freq_ref);
    check("run", {15'h0000, run}, {15'h0000, o_run});
    check("flag", {15'h0000, flag}, {15'h0000, o_flag});
  endtask
  // waits to just before a tick start; tick starts when cyc is a multiple of TK
  task automatic align();
    for (int k = 0; k <= 2 * TK; k++) begin
      @(posedge i_clk);
      if (cyc % TK == TK - 20) return;
    end
    n_fail++;
    $display("Error tick expected %h seen %h", 16'h0001, 16'h0000);
    end_of_test();
  endtask
  task automatic step(input logic [15:0] cmd, input logic [15:0] lvl, input int n);
    align();
    i_command <= cmd;
    level <= lvl;
    repeat (n) align();
  endtask
  task automatic do_reset();
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    logic [3:0] a [11] = '{ADDR_GAIN, ADDR_TI, ADDR_TD, ADDR_TF, ADDR_PFREQ, ADDR_AWU, ADDR_SFREQ,
      ADDR_LAT, ADDR_RFREQ, ADDR_IRQ_CLR, ADDR_STATUS};
    logic [15:0] r [11] = '{16'h0064, 0, 0, 0, 0, 16'h00C8, 0, 0, 0, 0, 0};
    logic [15:0] w [11] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0005,
      16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF};
    logic [15:0] s [11] = '{16'h7530, 16'h8CA0, 16'hEA60, 16'h2328, 16'h1388, 16'h00C8, 16'h000A,
      16'h003C, 16'h1388, 0, 0};
    for (int i = 0; i < 11; i++) begin
      rchk("reset value", a[i], r[i]);
      wr(a[i], w[i]);
      rchk("limited value", a[i], s[i]);
    end
    $display("test regs done");
  endtask
  task automatic t_pid();
    wr(ADDR_GAIN, 16'h03E8);
    step(16'h2710, 16'h0000, 1);
    outs(16'h09C4, 1'b1, 1'b0);
    rchk("freq reg", ADDR_FREQ, 16'h09C4);
    step(16'h2EE0, 16'h0000, 1);
    outs(16'h0BB8, 1'b1, 1'b0);
    wr(ADDR_TD, 16'h0001);
    step(16'h36B0, 16'h0000, 1);
    outs(16'h1388, 1'b1, 1'b0);
    align();
    outs(16'h0DAC, 1'b1, 1'b0);
    wr(ADDR_TD, 16'h0000);
    step(16'h36B0, 16'h0FA0, 1);
    rchk("filtered", ADDR_FILT, 16'h0FA0);
    outs(16'h09C4, 1'b1, 1'b0);
    wr(ADDR_TF, 16'h000A);
    step(16'h36B0, 16'h1F40, 1);
    rchk("filt step", ADDR_FILT, 16'h0FA4);
    check("filter lag", 16'h0001, {15'h0000, rv > 16'h0FA0 && rv < 16'h1F40});
    wr(ADDR_TF, 16'h0000);
    $display("test regulator done");
  endtask
  // integral of 1000 counts at 0.1 s adds 10 counts per tick; 5 % window is 1000 counts
  task automatic t_integ();
    wr(ADDR_AWU, 16'h0005);
    wr(ADDR_TI, 16'h0001);
    step(16'h2328, 16'h1F40, 1);
    outs(16'h00FC, 1'b1, 1'b0);
    align();
    outs(16'h00FF, 1'b1, 1'b0);
    step(16'h2AF8, 16'h1F40, 1);
    outs(16'h02F5, 1'b1, 1'b0);
    // zero integral time clears the integrator on the next tick
    wr(ADDR_TI, 16'h0000);
    $display("test integrator done");
  endtask
  task automatic t_slow();
    wr(ADDR_IRQ_EN, 16'h0007);
    wr(ADDR_SFREQ, 16'h03E8);
    wr(ADDR_RFREQ, 16'h01F4);
    step(16'h2AF8, 16'h1F40, 2);
    outs(16'h02EE, 1'b1, 1'b0);
    step(16'h1F40, 16'h1F40, 2);
    outs(16'h0000, 1'b0, 1'b1);
    rchk("status", ADDR_STATUS, 16'h0007);
    check("irq", 16'h0001, {15'h0000, o_irq});
    step(16'h2580, 16'h1F40, 1);
    outs(16'h0190, 1'b0, 1'b1);
    step(16'h28A0, 16'h1F40, 1);
    outs(16'h0258, 1'b1, 1'b0);
    rchk("irq stat", ADDR_IRQ_STAT, 16'h0003);
    wr(ADDR_IRQ_CLR, 16'h0007);
    rchk("irq cleared", ADDR_IRQ_STAT, 16'h0000);
    wr(ADDR_IRQ_EN, 16'h0000);
    step(16'h1F40, 16'h1F40, 2);
    outs(16'h0000, 1'b0, 1'b1);
    check("irq masked", 16'h0000, {15'h0000, o_irq});
    wr(ADDR_IRQ_EN, 16'h0001);
    #1 check("irq enabled", 16'h0001, {15'h0000, o_irq});
    step(16'h28A0, 16'h1F40, 1);
    wr(ADDR_SFREQ, 16'h0000);
    wr(ADDR_RFREQ, 16'h0000);
    step(16'h1F40, 16'h1F40, 2);
    outs(16'h0000, 1'b1, 1'b0);
    $display("test slow flow done");
  endtask
  task automatic t_press();
    wr(ADDR_IRQ_CLR, 16'h0007);
    wr(ADDR_IRQ_EN, 16'h0004);
    wr(ADDR_PFREQ, 16'h0320);
    wr(ADDR_PDUR, 16'h0001);
    wr(ADDR_RFREQ, 16'h05DC);
    wr(ADDR_SFREQ, 16'h03E8);
    step(16'h1F40, 16'h1F40, 2);
    rchk("status", ADDR_STATUS, 16'h0002);
    outs(16'h0320, 1'b1, 1'b0);
    check("irq press", 16'h0001, {15'h0000, o_irq});
    step(16'h3A98, 16'h0000, 1);
    rchk("held filter", ADDR_FILT, 16'h1F40);
    outs(16'h0320, 1'b1, 1'b0);
    do_reset();
    #1 outs(16'h0000, 1'b1, 1'b0);
    check("irq reset", 16'h0000, {15'h0000, o_irq});
    rchk("status reset", ADDR_STATUS, 16'h0000);
    $display("test pressurize done");
  endtask
  initial begin
    repeat (100000) @(posedge i_clk);
    n_fail++;
    $display("Error run time expected %h seen %h", 16'h0000, 16'h0001);
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs();
    do_reset();
    t_pid();
    t_integ();
    t_slow();
    t_press();
    end_of_test();
  end
endmodule
